// File: core/inlogic_pkg.sv
// package: constants and types for the input logic conversion block
package inlogic_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_MASK = 12'h004;
  localparam logic [11:0] OFF_EVENT = 12'h008;
  localparam logic [11:0] OFF_TIME = 12'h00c;
  localparam logic [11:0] OFF_LEVEL = 12'h010;
  localparam logic [11:0] OFF_CH_BASE = 12'h100;
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [2:0] CH_CTRL = 3'h0;
  localparam logic [2:0] CH_THR_A = 3'h1;
  localparam logic [2:0] CH_THR_B = 3'h2;
  localparam logic [2:0] CH_DEBOUNCE = 3'h3;
  localparam logic [2:0] CH_SMOOTH = 3'h4;
  // ---------------------------------------------------------------
  // control field layout
  // ---------------------------------------------------------------
  localparam int CTRL_TEST_LSB = 0;
  localparam int CTRL_NUMBER = 4;
  localparam int CTRL_INVERT = 5;
  localparam int CTRL_RECORD = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] DEBOUNCE_RESET = 16'h0000;
  localparam logic [3:0] SMOOTH_RESET = 4'h0;
  // ---------------------------------------------------------------
  // event codes and tests
  // ---------------------------------------------------------------
  localparam int FLAG_TRUE = 0;
  localparam int FLAG_RISE = 1;
  localparam int FLAG_FALL = 2;
  localparam logic [6:0] CODE_RISE = 7'h03;
  localparam logic [6:0] CODE_FALL = 7'h04;
  localparam int STROBE_MIN = 2;
  typedef enum logic [3:0] {
    T_ABOVE, T_BELOW, T_BETWEEN, T_OUTSIDE, T_RISING, T_FALLING,
    T_PEAK, T_VALLEY, T_TIP, T_RISE_THRU, T_FALL_THRU, T_PASS_THRU
  } test_e;
endpackage

// File: core/input_logic_conversion.sv
// input logic conversion: eight channels of smoothing, test, invert, debounce, events
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module input_logic_conversion
  import inlogic_pkg::*;
#(
  parameter int NCH = 8,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sample_stb,
  input wire logic [NCH*DW-1:0] sample_data,
  input wire logic [NCH-1:0] logic_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [NCH-1:0] level_out,
  output logic ev_valid,
  output logic [2:0] ev_chan,
  output logic [6:0] ev_code,
  output logic [31:0] ev_time
);
  // ---------------------------------------------------------------
  // input synchronisers (logic pins are asynchronous)
  // ---------------------------------------------------------------
  logic [NCH-1:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (ce) begin
      pin_s1_q <= logic_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q [NCH];
  logic signed [DW-1:0] thr_a_q [NCH];
  logic signed [DW-1:0] thr_b_q [NCH];
  logic [15:0] deb_q [NCH];
  logic [3:0] smooth_q [NCH];
  logic [NCH-1:0] status_q, mask_q;
  logic [31:0] time_q;
  logic [31:0] last_ev_q;

  wire wr = psel && penable && pwrite;
  wire in_ch = paddr >= OFF_CH_BASE && paddr < OFF_CH_BASE + 12'(NCH) * CH_STRIDE;
  wire [11:0] ch_rel = paddr - OFF_CH_BASE;
  wire [2:0] ch_idx = ch_rel[7:5];
  wire [2:0] ch_reg = ch_rel[4:2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= CTRL_RESET;
        thr_a_q[i] <= '0;
        thr_b_q[i] <= '0;
        deb_q[i] <= DEBOUNCE_RESET;
        smooth_q[i] <= SMOOTH_RESET;
      end
      mask_q <= '0;
    end else if (ce && wr) begin
      if (paddr == OFF_MASK)
        mask_q <= pwdata[NCH-1:0];
      if (in_ch) begin
        case (ch_reg)
          CH_CTRL: ctrl_q[ch_idx] <= pwdata;
          CH_THR_A: thr_a_q[ch_idx] <= pwdata[DW-1:0];
          CH_THR_B: thr_b_q[ch_idx] <= pwdata[DW-1:0];
          CH_DEBOUNCE: deb_q[ch_idx] <= pwdata[15:0];
          CH_SMOOTH: smooth_q[ch_idx] <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // per-channel processing
  // ---------------------------------------------------------------
  logic signed [DW+15:0] acc_q [NCH];
  logic signed [DW-1:0] prev_q [NCH];
  logic [1:0] slope_q [NCH];
  logic [NCH-1:0] have_prev_q, raw_q, stable_q, ev_rise, ev_fall;
  logic [15:0] deb_cnt_q [NCH];
  logic [1:0] run_q [NCH];
  logic [NCH-1:0] fall_armed_q;

  // one-pole low-pass: acc += x - acc>>k, output acc>>k
  function automatic logic signed [DW-1:0] smooth_out(input logic signed [DW+15:0] acc, input logic [3:0] k);
    smooth_out = DW'(acc >>> k);
  endfunction

  logic signed [DW-1:0] cur [NCH];
  logic [NCH-1:0] test_res;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      logic signed [DW-1:0] x, lo, hi;
      logic up, dn;
      x = $signed(sample_data[i*DW +: DW]);
      cur[i] = smooth_q[i] == 4'h0 ? x : smooth_out(acc_q[i], smooth_q[i]);
      lo = thr_a_q[i] < thr_b_q[i] ? thr_a_q[i] : thr_b_q[i];
      hi = thr_a_q[i] < thr_b_q[i] ? thr_b_q[i] : thr_a_q[i];
      up = have_prev_q[i] && cur[i] > prev_q[i];
      dn = have_prev_q[i] && cur[i] < prev_q[i];
      case (test_e'(ctrl_q[i][CTRL_TEST_LSB +: 4]))
        T_ABOVE: test_res[i] = cur[i] > thr_a_q[i];
        T_BELOW: test_res[i] = cur[i] < thr_a_q[i];
        T_BETWEEN: test_res[i] = cur[i] >= lo && cur[i] <= hi;
        T_OUTSIDE: test_res[i] = cur[i] < lo || cur[i] > hi;
        T_RISING: test_res[i] = up;
        T_FALLING: test_res[i] = dn;
        T_PEAK: test_res[i] = dn && slope_q[i] == 2'b01;
        T_VALLEY: test_res[i] = up && slope_q[i] == 2'b10;
        T_TIP: test_res[i] = (dn && slope_q[i] == 2'b01) || (up && slope_q[i] == 2'b10);
        T_RISE_THRU: test_res[i] = have_prev_q[i] && prev_q[i] <= thr_a_q[i] && cur[i] > thr_a_q[i];
        T_FALL_THRU: test_res[i] = have_prev_q[i] && prev_q[i] > thr_a_q[i] && cur[i] <= thr_a_q[i];
        T_PASS_THRU: test_res[i] = have_prev_q[i] && ((prev_q[i] <= thr_a_q[i]) != (cur[i] <= thr_a_q[i]));
        default: test_res[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        acc_q[i] <= '0;
        prev_q[i] <= '0;
        slope_q[i] <= 2'b00;
      end
      have_prev_q <= '0;
      raw_q <= '0;
    end else if (ce && sample_stb) begin
      for (int i = 0; i < NCH; i++) begin
        acc_q[i] <= acc_q[i] + (DW+16)'($signed(sample_data[i*DW +: DW])) - (acc_q[i] >>> smooth_q[i]);
        prev_q[i] <= cur[i];
        have_prev_q[i] <= 1'b1;
        if (cur[i] != prev_q[i])
          slope_q[i] <= cur[i] > prev_q[i] ? 2'b01 : 2'b10;
        raw_q[i] <= (ctrl_q[i][CTRL_NUMBER] ? test_res[i] : pin_s2_q[i]) ^ ctrl_q[i][CTRL_INVERT];
      end
    end
  end

  // debounce: counted in samples, accepted once stable for deb_q samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++)
        deb_cnt_q[i] <= '0;
      stable_q <= '0;
    end else if (ce && sample_stb) begin
      for (int i = 0; i < NCH; i++) begin
        if (deb_q[i] == 16'h0000 || raw_q[i] == stable_q[i]) begin
          stable_q[i] <= raw_q[i];
          deb_cnt_q[i] <= '0;
        end else if (deb_cnt_q[i] + 16'h0001 >= deb_q[i]) begin
          stable_q[i] <= raw_q[i];
          deb_cnt_q[i] <= '0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // edge detect and run length to qualify fall events
  logic [NCH-1:0] level_q, run_long;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      run_long[i] = run_q[i] == 2'd3;
      ev_rise[i] = sample_stb && stable_q[i] && !level_q[i];
      ev_fall[i] = sample_stb && !stable_q[i] && level_q[i] && fall_armed_q[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= '0;
      fall_armed_q <= '0;
      for (int i = 0; i < NCH; i++)
        run_q[i] <= '0;
    end else if (ce && sample_stb) begin
      level_q <= stable_q;
      for (int i = 0; i < NCH; i++) begin
        if (!stable_q[i])
          run_q[i] <= '0;
        else if (run_q[i] != 2'd3)
          run_q[i] <= run_q[i] + 2'd1;
        // fall is recorded only after more than STROBE_MIN true samples
        fall_armed_q[i] <= stable_q[i] && (32'(run_q[i]) + 1 > STROBE_MIN);
      end
    end
  end

  // ---------------------------------------------------------------
  // event recording, one event per clock, lowest channel wins and the other channels' events are dropped
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      time_q <= '0;
    else if (ce && sample_stb)
      time_q <= time_q + 32'h0000_0001;
  end

  logic [NCH-1:0] rec_rise, rec_fall;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rec_rise[i] = ev_rise[i] && ctrl_q[i][CTRL_RECORD];
      rec_fall[i] = ev_fall[i] && ctrl_q[i][CTRL_RECORD];
    end
  end
  wire [NCH-1:0] rec_low = (rec_rise | rec_fall) & ~((rec_rise | rec_fall) - NCH'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_valid <= 1'b0;
      ev_chan <= '0;
      ev_code <= '0;
      ev_time <= '0;
      level_out <= '0;
    end else if (ce) begin
      level_out <= stable_q;
      ev_valid <= 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
        if (rec_rise[i] || rec_fall[i]) begin
          ev_valid <= 1'b1;
          ev_chan <= 3'(i);
          ev_code <= rec_rise[i] ? CODE_RISE : CODE_FALL;
          ev_time <= time_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and bus
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status_q <= '0;
    else if (ce)
      status_q <= (status_q & ~((wr && paddr == OFF_STATUS) ? pwdata[NCH-1:0] : '0)) | rec_rise | rec_fall;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      last_ev_q <= '0;
    end else if (ce) begin
      irq <= |(status_q & mask_q);
      if (ev_valid)
        last_ev_q <= {ev_chan, 6'h00, ev_code, 16'h0000};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        if (!pwrite) begin
          if (paddr == OFF_STATUS) prdata <= 32'(status_q);
          else if (paddr == OFF_MASK) prdata <= 32'(mask_q);
          else if (paddr == OFF_EVENT) prdata <= last_ev_q;
          else if (paddr == OFF_TIME) prdata <= time_q;
          else if (paddr == OFF_LEVEL) prdata <= 32'(stable_q);
          else if (in_ch) begin
            case (ch_reg)
              CH_CTRL: prdata <= ctrl_q[ch_idx];
              CH_THR_A: prdata <= 32'(thr_a_q[ch_idx]);
              CH_THR_B: prdata <= 32'(thr_b_q[ch_idx]);
              CH_DEBOUNCE: prdata <= 32'(deb_q[ch_idx]);
              CH_SMOOTH: prdata <= 32'(smooth_q[ch_idx]);
              default: prdata <= '0;
            endcase
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rise_code: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(rec_rise & rec_low) |=> ev_valid && ev_code == 7'h03) else $error("rise code wrong");
  a_fall_code: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(rec_fall & rec_low) |=> ev_valid && ev_code == 7'h04) else $error("fall code wrong");
  a_event_record: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(|rec_rise) && !(|rec_fall) |=> !ev_valid) else $error("spurious event");
  a_no_short_fall: assert property (@(posedge pclk) disable iff (!presetn)
    |ev_fall |-> (ev_fall & ~run_long) == '0) else $error("fall without long high run");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 ce |-> irq == |($past(status_q) & $past(mask_q))) else $error("irq mismatch");
  a_debounce_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sample_stb && deb_q[0] == 16'h0000 |=> stable_q[0] == $past(raw_q[0])) else $error("debounce not bypassed");
  a_logic_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sample_stb && !ctrl_q[0][CTRL_NUMBER] |=> raw_q[0] == ($past(pin_s2_q[0]) ^ $past(ctrl_q[0][CTRL_INVERT])))
    else $error("logic path wrong");
  a_above_test: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[0][3:0] == 4'h0 |-> test_res[0] == (cur[0] > thr_a_q[0])) else $error("above test wrong");
  a_record_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ev_rise[0] && ctrl_q[0][CTRL_RECORD] |=> ev_valid && ev_chan == 3'h0 && ev_time == $past(time_q))
    else $error("rise not recorded");
endmodule

// File: verification/sig_source.sv
// partner model: sampled experiment signal source and logic pins
`timescale 1ns/10ps
module sig_source #(
  parameter int W = 128
) (
  input wire logic pclk,
  output logic sample_stb,
  output logic [W-1:0] sample_data,
  output logic [7:0] logic_in
);
  initial begin
    sample_stb = 1'b0;
    sample_data = '0;
    logic_in = 8'h00;
  end
  // one sample; with a gap the strobe drops and the bus shows junk, with none it stays up for the next
  task put(input logic [W-1:0] d, input int gap);
    sample_data <= d;
    sample_stb <= 1'b1;
    @(posedge pclk);
    if (gap > 0) begin
      sample_stb <= 1'b0;
      sample_data <= ~d;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // ends a run of back-to-back samples
  task stop();
    sample_stb <= 1'b0;
  endtask
  task pins(input logic [7:0] v);
    logic_in <= v;
  endtask
endmodule

// File: verification/input_logic_conversion_tb.sv
// testbench: conversion tests from a table, then reset, map, logic pins, interrupt and clock enable cases
`timescale 1ns/10ps
module input_logic_conversion_tb;
  import inlogic_pkg::*;
  typedef struct {test_e t; int a; int b; int k; logic [1:0] ri; logic [31:0] seq; int er; int ef; int dt;} row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, ev_time, t_r, t_f;
  logic pready, pslverr, irq, ev_valid, sample_stb, err;
  logic [7:0] level_out, logic_in;
  logic [2:0] ev_chan, l_ch;
  logic [6:0] ev_code;
  logic [127:0] sample_data;
  int failures = 0;
  int n_checks = 0;
  int n_r, n_f, n_x;
  // samples are nibbles times ten, first sample in the top nibble
  row_s rows[17] = '{
    '{T_ABOVE, 10, 30, 0, 2'b10, 32'h00222200, 1, 1, 4},
    '{T_BELOW, 10, 30, 0, 2'b10, 32'h22000022, 1, 1, 4},
    '{T_BETWEEN, 10, 30, 0, 2'b10, 32'h00222200, 1, 1, 4},
    '{T_OUTSIDE, 10, 30, 0, 2'b10, 32'h22000022, 1, 1, 4},
    '{T_RISING, 10, 30, 0, 2'b10, 32'h00123444, 1, 1, 4},
    '{T_FALLING, 10, 30, 0, 2'b10, 32'h44321000, 1, 1, 4},
    '{T_PEAK, 10, 30, 0, 2'b10, 32'h00121000, 1, 0, 0},
    '{T_VALLEY, 10, 30, 0, 2'b10, 32'h22101222, 1, 0, 0},
    '{T_TIP, 10, 30, 0, 2'b10, 32'h00121011, 2, 0, 0},
    '{T_RISE_THRU, 10, 30, 0, 2'b10, 32'h00220022, 2, 0, 0},
    '{T_FALL_THRU, 10, 30, 0, 2'b10, 32'h00220022, 1, 0, 0},
    '{T_PASS_THRU, 10, 30, 0, 2'b10, 32'h00220022, 3, 0, 0},
    '{T_ABOVE, 10, 30, 0, 2'b10, 32'h00220000, 1, 0, 0},
    '{T_ABOVE, 10, 30, 0, 2'b10, 32'h00222000, 1, 1, 3},
    '{T_ABOVE, 10, 30, 0, 2'b11, 32'h00222200, 2, 0, 0},
    '{T_ABOVE, 10, 30, 0, 2'b00, 32'h00222200, 0, 0, 0},
    '{T_ABOVE, 20, 30, 2, 2'b10, 32'h00400000, 0, 0, 0}
  };
  always #2.5 pclk = ~pclk;
  sig_source sig_source_i(.pclk(pclk), .sample_stb(sample_stb), .sample_data(sample_data), .logic_in(logic_in));
  input_logic_conversion input_logic_conversion_i(.pclk(pclk), .presetn(presetn), .ce(ce),
    .sample_stb(sample_stb), .sample_data(sample_data), .logic_in(logic_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .level_out(level_out), .ev_valid(ev_valid), .ev_chan(ev_chan), .ev_code(ev_code),
    .ev_time(ev_time));
  // ----------------------------------------
  // event monitor and helpers
  // ----------------------------------------
  always @(posedge pclk) begin
    if (ev_valid === 1'b1) begin
      l_ch = ev_chan;
      if (ev_code === CODE_RISE) begin
        n_r++;
        t_r = ev_time;
      end else if (ev_code === CODE_FALL) begin
        n_f++;
        t_f = ev_time;
      end else begin
        n_x++;
      end
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  function logic [11:0] ca(input int c, input logic [2:0] r);
    return OFF_CH_BASE + 12'(c) * CH_STRIDE + 12'({r, 2'b00});
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task feed(input int n);
    repeat (n) sig_source_i.put('0, 3);
  endtask
  task final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    foreach (rows[i]) begin
      rst();
      apb(1'b1, ca(0, CH_THR_A), 32'(rows[i].a));
      apb(1'b1, ca(0, CH_THR_B), 32'(rows[i].b));
      apb(1'b1, ca(0, CH_SMOOTH), 32'(rows[i].k));
      apb(1'b1, ca(0, CH_CTRL), {25'h0, rows[i].ri, 1'b1, 4'(rows[i].t)});
      n_r = 0;
      n_f = 0;
      n_x = 0;
      // last sample repeated twice: events show two samples late
      for (int s = 7; s >= -2; s--) sig_source_i.put({112'h0, 16'(rows[i].seq[(s < 0 ? 0 : s) * 4 +: 4] * 10)}, i % 3);
      sig_source_i.stop();
      repeat (8) @(posedge pclk);
      check(n_r, rows[i].er, "rise count");
      check(n_f, rows[i].ef, "fall count");
      check(n_x, 0, "odd code");
      if (rows[i].ef > 0) check(t_f - t_r, rows[i].dt, "time span");
      if (rows[i].er > 0) check(32'(l_ch), 0, "channel");
      $display("row %0d done", i);
    end
    rst();
    apb(1'b0, ca(0, CH_CTRL), '0);
    check(rd, CTRL_RESET, "ctrl reset");
    apb(1'b0, ca(0, CH_DEBOUNCE), '0);
    check(rd, 32'(DEBOUNCE_RESET), "debounce reset");
    apb(1'b0, ca(0, CH_SMOOTH), '0);
    check(rd, 32'(SMOOTH_RESET), "smooth reset");
    apb(1'b1, 12'h0f0, 32'hffff_ffff);
    apb(1'b0, 12'h0f0, '0);
    check(rd, '0, "unmapped read");
    check(32'(err), '0, "slave error");
    apb(1'b1, ca(7, CH_CTRL), 32'h0000_0045);
    apb(1'b0, ca(7, CH_CTRL), '0);
    check(rd, 32'h0000_0045, "ch7 ctrl");
    $display("reset and map done");
    sig_source_i.pins(8'h08);
    feed(4);
    apb(1'b1, ca(3, CH_CTRL), 32'h0000_0060);
    feed(4);
    n_r = 0;
    n_f = 0;
    sig_source_i.pins(8'h00);
    feed(4);
    check(n_r, 1, "pin rise");
    check(32'(l_ch), 3, "pin channel");
    check(32'(level_out[3]), 1, "inverted level");
    apb(1'b1, ca(3, CH_DEBOUNCE), 32'h0000_0003);
    sig_source_i.pins(8'h08);
    feed(1);
    sig_source_i.pins(8'h00);
    feed(6);
    check(n_f, 0, "glitch kept out");
    sig_source_i.pins(8'h08);
    feed(8);
    check(n_f, 1, "settled fall");
    check(32'(level_out[3]), 0, "settled level");
    $display("logic pin case done");
    apb(1'b0, OFF_STATUS, '0);
    check(rd & 32'h08, 32'h08, "status bit");
    check(32'(irq), 0, "masked irq");
    apb(1'b1, OFF_MASK, 32'h08);
    repeat (2) @(posedge pclk);
    check(32'(irq), 1, "irq raised");
    apb(1'b1, OFF_STATUS, 32'h08);
    repeat (2) @(posedge pclk);
    check(32'(irq), 0, "irq cleared");
    apb(1'b0, OFF_STATUS, '0);
    check(rd, '0, "status cleared");
    $display("interrupt case done");
    apb(1'b0, OFF_TIME, '0);
    t_r = rd;
    ce <= 1'b0;
    feed(2);
    ce <= 1'b1;
    apb(1'b0, OFF_TIME, '0);
    check(rd, t_r, "time frozen while ce low");
    feed(1);
    apb(1'b0, OFF_TIME, '0);
    check(rd, t_r + 32'h0000_0001, "time after one sample");
    $display("clock enable case done");
    final_report();
  end
endmodule
